// [hdl/sfe_pkg.sv]
// constants, types and command codes shared by the serial flash command front end
package sfe_pkg;

	// command codes
	localparam logic [7:0] OP_READ = 8'h03;
	localparam logic [7:0] OP_FAST_READ = 8'h0B;
	localparam logic [7:0] OP_SECT_ERASE = 8'h20;
	localparam logic [7:0] OP_BLK32_ERASE = 8'h52;
	localparam logic [7:0] OP_BLK64_ERASE = 8'hD8;
	localparam logic [7:0] OP_CHIP_ERASE_A = 8'h60;
	localparam logic [7:0] OP_CHIP_ERASE_B = 8'hC7;
	localparam logic [7:0] OP_BYTE_PROG = 8'h02;
	localparam logic [7:0] OP_AUTO_PROG = 8'hAD;
	localparam logic [7:0] OP_STATUS_READ = 8'h05;
	localparam logic [7:0] OP_STATUS_UNLOCK = 8'h50;
	localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
	localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
	localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
	localparam logic [7:0] OP_ID_READ_A = 8'h90;
	localparam logic [7:0] OP_ID_READ_B = 8'hAB;
	localparam logic [7:0] OP_STD_ID_READ = 8'h9F;
	localparam logic [7:0] OP_BUSY_SO_EN = 8'h70;
	localparam logic [7:0] OP_BUSY_SO_DIS = 8'h80;

	// framing counts
	localparam logic [2:0] BIT_LAST = 3'h7;
	localparam logic [1:0] ADDR_LAST = 2'h2;
	localparam logic [1:0] ID_LAST = 2'h2;

	// status byte layout: lock, auto mode, level[3:0], write latch, busy
	localparam int ST_BUSY = 0;
	localparam int ST_LATCH = 1;
	localparam int ST_LEVEL_LO = 2;
	localparam int ST_AUTO = 6;
	localparam int ST_LOCK = 7;

	// values after reset
	localparam logic LOCK_RST = 1'h0;
	localparam logic [3:0] LEVEL_RST = 4'h7;

	// array geometry and erase spans
	localparam logic [23:0] ARRAY_TOP = 24'h1FFFFF;
	localparam logic [23:0] SECT_SPAN = 24'h000FFF;
	localparam logic [23:0] BLK32_SPAN = 24'h007FFF;
	localparam logic [23:0] BLK64_SPAN = 24'h00FFFF;
	localparam logic [23:0] WORD_SPAN = 24'h000001;
	localparam logic [23:0] WORD_STEP = 24'h000002;

	// lowest protected address per level; level 0 lies above the array
	localparam logic [23:0] PROT_BASE [8] = '{24'h200000, 24'h1F0000, 24'h1E0000, 24'h1C0000,
		24'h180000, 24'h100000, 24'h000000, 24'h000000};

	typedef enum logic [6:0] {
		ST_OPC = 7'h01,
		ST_ADDR = 7'h02,
		ST_DUMMY = 7'h04,
		ST_DIN = 7'h08,
		ST_DOUT = 7'h10,
		ST_DONE = 7'h20,
		ST_IGN = 7'h40
	} sfe_state_t;

	typedef enum logic [2:0] {
		REQ_BYTE = 3'h0,
		REQ_WORD = 3'h1,
		REQ_SECT = 3'h2,
		REQ_BLK32 = 3'h3,
		REQ_BLK64 = 3'h4,
		REQ_CHIP = 3'h5
	} sfe_req_kind_t;

	typedef struct packed {
		sfe_req_kind_t kind;
		logic [23:0] addr;
		logic [15:0] data;
	} sfe_req_t;

	typedef struct packed {
		logic chipSelN;
		logic sclk;
		logic serIn;
		logic wpN;
	} sfe_pins_t;

	localparam sfe_pins_t PINS_IDLE = '{chipSelN: 1'b1, sclk: 1'b0, serIn: 1'b0, wpN: 1'b1};
	localparam int REQ_W = $bits(sfe_req_t);

endpackage

// [hdl/sfe_front_end.sv]
// serial flash command front end with its write request fifo
`timescale 1ns/1ns

module sfe_fifo import sfe_pkg::*; #(
	parameter int WIDTH = REQ_W,
	parameter int DEPTH = 16
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wrPtr_r;
	logic [AW:0] rdPtr_r;

	// extra pointer bit tells full from empty without a counter
	assign outValid = wrPtr_r != rdPtr_r;
	assign inReady = (wrPtr_r[AW] == rdPtr_r[AW]) || (wrPtr_r[AW-1:0] != rdPtr_r[AW-1:0]);
	assign outData = mem[rdPtr_r[AW-1:0]];

	// storage needs no reset, only pointers define content
	always_ff @(posedge sys_clk) begin
		if (inValid && inReady) begin
			mem[wrPtr_r[AW-1:0]] <= inData;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			wrPtr_r <= '0;
		end else if (inValid && inReady) begin
			wrPtr_r <= wrPtr_r + {{AW{1'b0}}, 1'b1};
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			rdPtr_r <= '0;
		end else if (outValid && outReady) begin
			rdPtr_r <= rdPtr_r + {{AW{1'b0}}, 1'b1};
		end
	end
endmodule // sfe_fifo

module sfe_front_end import sfe_pkg::*; #(
	parameter logic [7:0] MAKER_ID = 8'h5A, // arbitrary value
	parameter logic [7:0] DEVICE_ID = 8'h3C, // arbitrary value
	parameter logic [7:0] ID_TYPE = 8'h26, // arbitrary value
	parameter logic [7:0] ID_CAPACITY = 8'h41, // arbitrary value
	parameter int FIFO_DEPTH = 16
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire sfe_pins_t pins,
	output logic soOut,
	output logic soOe,
	output logic [23:0] memAddr,
	input wire logic [7:0] memRdData,
	output logic reqValid,
	input wire logic reqReady,
	output sfe_req_t reqData,
	input wire logic arrayBusy,
	output logic [7:0] statusByte
);
	sfe_pins_t pinMeta_r;
	sfe_pins_t pinSync_r;
	logic sclkPrev_r;
	logic csPrev_r;
	logic csAct;
	logic csRise;
	logic sckRise;
	logic sckFall;
	logic [2:0] bitCnt_r;
	logic [7:0] shIn_r;
	logic [7:0] rxByte;
	logic byteDone;
	sfe_state_t state_r;
	sfe_state_t opcNext;
	sfe_state_t addrNext;
	logic [7:0] opcode_r;
	logic [1:0] byteCnt_r;
	logic [23:0] addr_r;
	logic [1:0] idIdx_r;
	logic [15:0] dataBuf_r;
	logic [7:0] shOut_r;
	logic soBit_r;
	logic [7:0] txByte;
	logic writeLatch_r;
	logic protLock_r;
	logic [3:0] protLevel_r;
	logic autoProgMode_r;
	logic busyToSo_r;
	logic statusUnlock_r;
	logic [23:0] aaiAddr_r;
	logic pend_r;
	sfe_req_t pendReq_r;
	logic fifoInReady;
	logic busyNow;
	logic hwBusy;
	logic execNow;
	logic isWriteOp;
	logic protHit;
	logic cmdAllowed;
	logic [23:0] tgtBase;
	logic [23:0] tgtSpan;
	logic [23:0] tgtStart;
	logic [23:0] tgtEnd;
	sfe_req_kind_t reqKind;

	// pins come from the host domain, two flops before any use
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			pinMeta_r <= PINS_IDLE;
			pinSync_r <= PINS_IDLE;
			sclkPrev_r <= 1'b0;
			csPrev_r <= 1'b0;
		end else begin
			pinMeta_r <= pins;
			pinSync_r <= pinMeta_r;
			sclkPrev_r <= pinSync_r.sclk;
			csPrev_r <= !pinSync_r.chipSelN;
		end
	end

	// edges found independently of clock idle level
	assign csAct = !pinSync_r.chipSelN;
	assign csRise = csPrev_r && !csAct;
	assign sckRise = csAct && pinSync_r.sclk && !sclkPrev_r;
	assign sckFall = csAct && !pinSync_r.sclk && sclkPrev_r;

	// input shifter; bit count restarts whenever select is released
	assign rxByte = {shIn_r[6:0], pinSync_r.serIn};
	assign byteDone = sckRise && (bitCnt_r == BIT_LAST);

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			bitCnt_r <= '0;
			shIn_r <= '0;
		end else if (!csAct) begin
			bitCnt_r <= '0;
		end else if (sckRise) begin
			shIn_r <= rxByte;
			bitCnt_r <= bitCnt_r + 3'h1;
		end
	end

	// what follows the opcode byte
	always_comb begin
		unique case (rxByte)
			OP_READ, OP_FAST_READ, OP_BYTE_PROG, OP_ID_READ_A, OP_ID_READ_B: opcNext = ST_ADDR;
			OP_SECT_ERASE, OP_BLK32_ERASE, OP_BLK64_ERASE: opcNext = ST_ADDR;
			OP_AUTO_PROG: opcNext = autoProgMode_r ? ST_DIN : ST_ADDR;
			OP_STATUS_READ, OP_STD_ID_READ: opcNext = ST_DOUT;
			OP_STATUS_WRITE: opcNext = ST_DIN;
			OP_WRITE_ENABLE, OP_WRITE_DISABLE, OP_STATUS_UNLOCK, OP_CHIP_ERASE_A, OP_CHIP_ERASE_B: opcNext = ST_DONE;
			OP_BUSY_SO_EN, OP_BUSY_SO_DIS: opcNext = ST_DONE;
			default: opcNext = ST_IGN;
		endcase
	end

	// what follows the third address byte
	always_comb begin
		unique case (opcode_r)
			OP_FAST_READ: addrNext = ST_DUMMY;
			OP_READ, OP_ID_READ_A, OP_ID_READ_B: addrNext = ST_DOUT;
			OP_BYTE_PROG, OP_AUTO_PROG: addrNext = ST_DIN;
			default: addrNext = ST_DONE; // erases carry no data
		endcase
	end

	// command framing; deselect always returns to opcode decode
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			state_r <= ST_OPC;
			opcode_r <= '0;
			byteCnt_r <= '0;
		end else if (!csAct) begin
			state_r <= ST_OPC;
			byteCnt_r <= '0;
		end else if (byteDone) begin
			unique case (state_r)
				ST_OPC: begin
					opcode_r <= rxByte;
					state_r <= opcNext;
				end
				ST_ADDR: begin
					byteCnt_r <= byteCnt_r + 2'h1;
					if (byteCnt_r == ADDR_LAST) begin
						byteCnt_r <= '0;
						state_r <= addrNext;
					end
				end
				ST_DUMMY: state_r <= ST_DOUT; // one whole dummy byte
				ST_DIN: begin
					byteCnt_r <= byteCnt_r + 2'h1;
					// one data byte, or two for auto-increment
					if (opcode_r != OP_AUTO_PROG || byteCnt_r == 2'h1) begin
						state_r <= ST_DONE;
					end
				end
				ST_DOUT, ST_DONE, ST_IGN: state_r <= state_r; // surplus bytes ignored
			endcase
		end
	end

	// address capture and read pointer with wrap at the top
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			addr_r <= '0;
			idIdx_r <= '0;
		end else if (byteDone && state_r == ST_OPC) begin
			addr_r <= '0;
			idIdx_r <= '0;
		end else if (byteDone && state_r == ST_ADDR) begin
			addr_r <= {addr_r[15:0], rxByte}; // msb first
		end else if (byteDone && state_r == ST_DOUT) begin
			addr_r <= (addr_r + 24'h1) & ARRAY_TOP;
			idIdx_r <= (idIdx_r == ID_LAST) ? 2'h0 : idIdx_r + 2'h1;
		end
	end

	assign memAddr = addr_r & ARRAY_TOP;

	// data bytes of program and status write commands
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			dataBuf_r <= '0;
		end else if (byteDone && state_r == ST_DIN) begin
			dataBuf_r <= {dataBuf_r[7:0], rxByte};
		end
	end

	// byte to send next, chosen by the command in progress
	always_comb begin
		unique case (opcode_r)
			OP_READ, OP_FAST_READ: txByte = memRdData;
			OP_STATUS_READ: txByte = statusByte; // repeats every byte
			OP_ID_READ_A, OP_ID_READ_B: txByte = addr_r[0] ? DEVICE_ID : MAKER_ID;
			OP_STD_ID_READ: txByte = (idIdx_r == 2'h0) ? MAKER_ID : ((idIdx_r == 2'h1) ? ID_TYPE : ID_CAPACITY);
			default: txByte = 8'hFF;
		endcase
	end

	// busy indication replaces data only while auto-increment mode lasts
	assign busyNow = pend_r || reqValid || arrayBusy;
	assign hwBusy = autoProgMode_r && busyToSo_r;

	// output shifter changes after falling edges, loads a byte at each boundary
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			shOut_r <= '0;
			soBit_r <= 1'b0;
		end else if (!csAct) begin
			shOut_r <= '0;
			soBit_r <= 1'b0;
		end else if (state_r == ST_DOUT) begin
			if (sckFall && bitCnt_r == 3'h0) begin
				soBit_r <= txByte[7];
				shOut_r <= {txByte[6:0], 1'b0};
			end else if (sckFall) begin
				soBit_r <= shOut_r[7];
				shOut_r <= {shOut_r[6:0], 1'b0};
			end
		end else if (hwBusy) begin
			soBit_r <= !busyNow; // low while busy
		end
	end

	assign soOut = soBit_r;
	assign soOe = csAct && (state_r == ST_DOUT || (hwBusy && state_r != ST_IGN));

	// write target and its protection
	always_comb begin
		tgtBase = addr_r & ARRAY_TOP;
		tgtSpan = '0;
		reqKind = REQ_BYTE;
		isWriteOp = 1'b1;
		unique case (opcode_r)
			OP_BYTE_PROG: reqKind = REQ_BYTE;
			OP_AUTO_PROG: begin
				tgtBase = autoProgMode_r ? aaiAddr_r : (addr_r & ARRAY_TOP);
				tgtSpan = WORD_SPAN;
				reqKind = REQ_WORD;
			end
			OP_SECT_ERASE: begin
				tgtSpan = SECT_SPAN; // bits below 12 ignored
				reqKind = REQ_SECT;
			end
			OP_BLK32_ERASE: begin
				tgtSpan = BLK32_SPAN;
				reqKind = REQ_BLK32;
			end
			OP_BLK64_ERASE: begin
				tgtSpan = BLK64_SPAN;
				reqKind = REQ_BLK64;
			end
			OP_CHIP_ERASE_A, OP_CHIP_ERASE_B: begin
				tgtSpan = ARRAY_TOP; // any protected part blocks it
				reqKind = REQ_CHIP;
			end
			default: isWriteOp = 1'b0;
		endcase
	end

	assign tgtStart = tgtBase & ~tgtSpan;
	assign tgtEnd = tgtStart | tgtSpan;
	// level bit 3 is reserved and never enters the range
	assign protHit = tgtEnd >= PROT_BASE[protLevel_r[2:0]];
	// whole final byte, no partial one, and still framed as complete
	assign execNow = csRise && state_r == ST_DONE && bitCnt_r == 3'h0;
	// in auto-increment mode only continuation and write disable act
	assign cmdAllowed = !autoProgMode_r || opcode_r == OP_AUTO_PROG || opcode_r == OP_WRITE_DISABLE;

	// status bits, auto-increment state and the pending request
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			writeLatch_r <= 1'b0;
			protLock_r <= LOCK_RST;
			protLevel_r <= LEVEL_RST;
			autoProgMode_r <= 1'b0;
			busyToSo_r <= 1'b0;
			statusUnlock_r <= 1'b0;
			aaiAddr_r <= '0;
			pend_r <= 1'b0;
			pendReq_r <= '0;
		end else begin
			if (pend_r && fifoInReady) begin
				pend_r <= 1'b0;
			end
			if (execNow && cmdAllowed) begin
				unique case (opcode_r)
					OP_WRITE_ENABLE: writeLatch_r <= 1'b1;
					OP_WRITE_DISABLE: begin
						writeLatch_r <= 1'b0;
						autoProgMode_r <= 1'b0;
					end
					OP_STATUS_UNLOCK: statusUnlock_r <= 1'b1;
					OP_STATUS_WRITE: begin
						// pin high overrides the lock; pin low with lock set freezes
						if ((writeLatch_r || statusUnlock_r) && (pinSync_r.wpN || !protLock_r)) begin
							protLock_r <= dataBuf_r[ST_LOCK];
							protLevel_r <= dataBuf_r[ST_AUTO-1:ST_LEVEL_LO];
						end
						writeLatch_r <= 1'b0;
						statusUnlock_r <= 1'b0;
					end
					OP_BUSY_SO_EN: busyToSo_r <= 1'b1;
					OP_BUSY_SO_DIS: busyToSo_r <= 1'b0;
					default: begin
						// protected targets are dropped silently
						if (isWriteOp && writeLatch_r && !pend_r && !protHit) begin
							pend_r <= 1'b1; // self-timed write begins here
							pendReq_r <= '{kind: reqKind, addr: tgtStart, data: dataBuf_r};
							if (reqKind == REQ_WORD) begin
								autoProgMode_r <= 1'b1;
								aaiAddr_r <= (tgtStart + WORD_STEP) & ARRAY_TOP;
								// no wrap while programming: the top word ends the mode
								if (tgtEnd == ARRAY_TOP) begin
									autoProgMode_r <= 1'b0;
									writeLatch_r <= 1'b0;
								end
							end else begin
								writeLatch_r <= 1'b0;
							end
						end
					end
				endcase
			end
		end
	end

	// registered status image; one cycle behind its sources
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			statusByte <= {LOCK_RST, 1'b0, LEVEL_RST, 1'b0, 1'b0};
		end else begin
			statusByte <= {protLock_r, autoProgMode_r, protLevel_r, writeLatch_r, busyNow};
		end
	end

	// a stalled back end holds the request here; busy stays set meanwhile
	sfe_fifo #(
		.WIDTH(REQ_W),
		.DEPTH(FIFO_DEPTH)
	) reqFifo (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.inValid(pend_r),
		.inReady(fifoInReady),
		.inData(pendReq_r),
		.outValid(reqValid),
		.outReady(reqReady),
		.outData(reqData)
	);
endmodule // sfe_front_end

// [verification/sfe_host_model.sv]
// spi host model driving the link pins of the flash front end
`timescale 1ns/1ns
module sfe_host_model import sfe_pkg::*; (
	input wire logic wpN,
	input wire logic soOut,
	input wire logic soOe,
	output sfe_pins_t pins
);
	logic csN = 1'b1;
	logic sck = 1'b0;
	logic sdo = 1'b0;
	logic idleHi = 1'b0;
	// mode 0 or mode 3: the link clock stands still at idleHi between frames
	assign pins = '{chipSelN: csN, sclk: sck, serIn: sdo, wpN: wpN};
	// select goes low before the first bit
	task sel();
		// park the clock well before select falls so no false rise is seen
		sck = idleHi;
		#20 csN = 1'b0;
		#40;
	endtask
	// msb first, bit launched on the fall, output taken late in the high phase
	task xfer(input logic [7:0] tx, input int nb, output logic [7:0] rx, output logic oe);
		int i;
		for (i = 7; i > 7 - nb; i--) begin
			sck = 1'b0;
			sdo = tx[i];
			#40 sck = 1'b1;
			#38 rx[i] = soOut;
			oe = soOe;
			#2;
		end
	endtask
	// deselect after the last bit; the released line shows the inverse, not a held value
	task desel();
		#40 sck = idleHi;
		#40 csN = 1'b1;
		sdo = ~sdo;
		#200;
	endtask
endmodule // sfe_host_model

// [verification/sfe_front_end_properties.sv]
// concurrent checks on the ports of the flash command front end
`timescale 1ns/1ns
module sfe_front_end_chk import sfe_pkg::*; (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire sfe_pins_t pins,
	input wire logic soOe,
	input wire logic [23:0] memAddr,
	input wire logic reqValid,
	input wire logic reqReady,
	input wire sfe_req_t reqData,
	input wire logic arrayBusy,
	input wire logic [7:0] statusByte
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	logic [2:0] csHighCnt_r;
	logic [2:0] wpLowCnt_r;
	// consecutive cycles with select high, saturating; pins pass a synchroniser first
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) csHighCnt_r <= 3'h0;
		else if (!pins.chipSelN) csHighCnt_r <= 3'h0;
		else if (csHighCnt_r != 3'h7) csHighCnt_r <= csHighCnt_r + 3'h1;
	end
	// consecutive cycles with write protect low, saturating at four
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) wpLowCnt_r <= 3'h0;
		else if (pins.wpN) wpLowCnt_r <= 3'h0;
		else if (wpLowCnt_r != 3'h4) wpLowCnt_r <= wpLowCnt_r + 3'h1;
	end
	chk_oe_released: assert property (csHighCnt_r >= 3'h6 |-> !soOe)
		else $error("output enable still high after deselect");
	chk_req_holds: assert property (reqValid && !reqReady |=> reqValid && $stable(reqData))
		else $error("request changed before it was taken");
	chk_req_after_desel: assert property ($rose(reqValid) |-> csHighCnt_r >= 3'h3)
		else $error("request raised while still selected");
	chk_lock_freeze: assert property (wpLowCnt_r == 3'h4 && $past(statusByte[ST_LOCK])
		|-> $stable({statusByte[ST_LOCK], statusByte[5:2]}))
		else $error("locked protection bits changed");
	chk_reset_status: assert property ($rose(nrst) |-> statusByte == {LOCK_RST, 1'b0, LEVEL_RST, 2'b00})
		else $error("status after reset wrong");
	chk_addr_wrap: assert property ($changed(memAddr) && $past(memAddr) == ARRAY_TOP |-> memAddr == 24'h000000)
		else $error("read address beyond array");
	chk_prot_prog: assert property ($rose(reqValid) && reqData.kind inside {REQ_BYTE, REQ_WORD}
		|-> reqData.addr < PROT_BASE[statusByte[4:2]])
		else $error("program issued into protected range");
	chk_chip_prot: assert property ($rose(reqValid) && reqData.kind == REQ_CHIP |-> statusByte[4:2] == 3'h0)
		else $error("chip erase issued while protected");
	chk_busy_track: assert property (arrayBusy |-> ##[0:2] statusByte[ST_BUSY])
		else $error("busy bit missed array busy");
	cov_pop: cover property (reqValid && reqReady);
	cov_drive: cover property (soOe);
	cov_locked: cover property (wpLowCnt_r == 3'h4 && statusByte[ST_LOCK]);
endmodule // sfe_front_end_chk

bind sfe_front_end sfe_front_end_chk chk_u (.sys_clk(sys_clk), .nrst(nrst), .pins(pins), .soOe(soOe),
	.memAddr(memAddr), .reqValid(reqValid), .reqReady(reqReady), .reqData(reqData), .arrayBusy(arrayBusy),
	.statusByte(statusByte));

// [verification/sfe_front_end_tb.sv]
// self-checking bench for the flash command front end
`timescale 1ns/1ns
module sfe_front_end_tb import sfe_pkg::*;;
	typedef struct {logic [47:0] tx; int ntx; int nrx; logic [23:0] rx; logic wr; logic [REQ_W-1:0] e;
		logic [REQ_W-1:0] m;} sfe_row_t;
	localparam logic [REQ_W-1:0] M_BYTE = {3'h7, 24'hFFFFFF, 16'h00FF};
	localparam logic [REQ_W-1:0] M_WORD = {3'h7, 24'hFFFFFF, 16'hFFFF};
	localparam logic [REQ_W-1:0] M_KIND = {3'h7, 40'h0};
	logic sys_clk = 1'b0;
	logic nrst = 1'b0;
	logic wpN = 1'b1;
	logic reqReady = 1'b0;
	logic arrayBusy = 1'b0;
	logic [7:0] memRdData = 8'h00;
	sfe_pins_t pins;
	logic soOut, soOe, reqValid;
	logic [23:0] memAddr;
	logic [7:0] statusByte;
	sfe_req_t reqData;
	int fails = 0;
	int compares = 0;
	int cycles = 0;
	sfe_row_t rows[$];
	logic [7:0] r;
	logic oe;
	int i, n;
	always #5 sys_clk = ~sys_clk;
	sfe_front_end dut_u (.sys_clk(sys_clk), .nrst(nrst), .pins(pins), .soOut(soOut), .soOe(soOe),
		.memAddr(memAddr), .memRdData(memRdData), .reqValid(reqValid), .reqReady(reqReady), .reqData(reqData),
		.arrayBusy(arrayBusy), .statusByte(statusByte));
	sfe_host_model host_u (.wpN(wpN), .soOut(soOut), .soOe(soOe), .pins(pins));
	// array model: byte is a function of its address, ready one cycle after the address
	always @(posedge sys_clk) memRdData <= memAddr[7:0] + 8'h11;
	// hang guard well above the expected run length
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 60000) begin
			fails++;
			test_done();
		end
	end
	task test_done();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task chk_val(input string nm, input logic [7:0] e, input logic [7:0] g);
		compares++;
		if (g !== e) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	task chk_req(input string nm, input logic [REQ_W-1:0] e, input logic [REQ_W-1:0] g);
		compares++;
		if (g !== e) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	// back end takes the head request for one cycle, then lets outputs settle
	task pop();
		@(posedge sys_clk) reqReady <= 1'b1;
		@(posedge sys_clk) reqReady <= 1'b0;
		#1;
	endtask
	// optional write enable frame, then one frame; hold skips the request check to let the fifo fill
	task exec(input logic [47:0] tx, input int ntx, input int nrx, input logic [23:0] rx, input logic wr,
		input logic [REQ_W-1:0] e, input logic [REQ_W-1:0] m, input logic hold);
		int k;
		if (wr) begin
			host_u.sel();
			host_u.xfer(OP_WRITE_ENABLE, 8, r, oe);
			host_u.desel();
		end
		host_u.sel();
		for (k = 0; k < ntx; k++) host_u.xfer(tx[8*(ntx-1-k) +: 8], 8, r, oe);
		for (k = 0; k < nrx; k++) begin
			host_u.xfer(8'h00, 8, r, oe);
			chk_val("soOe", 8'h01, {7'h0, oe});
			chk_val("read byte", rx[8*(nrx-1-k) +: 8], r);
		end
		host_u.desel();
		if (!hold) begin
			chk_val("reqValid", {7'h0, m != 0}, {7'h0, reqValid});
			if (m != 0) begin
				chk_req("request", e, reqData & m);
				pop();
			end
		end
	endtask
	initial begin
		// ordinary commands, one row each
		rows.push_back('{48'h0100, 2, 0, 0, 1, 0, 0});
		rows.push_back('{48'h50, 1, 0, 0, 0, 0, 0});
		rows.push_back('{48'h0108, 2, 0, 0, 0, 0, 0});
		rows.push_back('{48'h05, 1, 1, 24'h08, 0, 0, 0});
		rows.push_back('{48'h0100, 2, 0, 0, 1, 0, 0});
		rows.push_back('{48'h05, 1, 2, 24'h0202, 1, 0, 0});
		rows.push_back('{48'h031FFFFF, 4, 2, 24'h1011, 0, 0, 0});
		rows.push_back('{48'h0B00001000, 5, 1, 24'h21, 0, 0, 0});
		rows.push_back('{48'h90000000, 4, 2, {8'h0, 8'h5A, 8'h3C}, 0, 0, 0});
		rows.push_back('{48'hAB000001, 4, 1, 24'h3C, 0, 0, 0});
		rows.push_back('{48'h9F, 1, 3, 24'h5A2641, 0, 0, 0});
		rows.push_back('{48'h02012345A5, 5, 0, 0, 1, {REQ_BYTE, 24'h012345, 16'h00A5}, M_BYTE});
		rows.push_back('{48'h02012346A5, 5, 0, 0, 0, 0, 0});
		rows.push_back('{48'h20012FFF, 4, 0, 0, 1, {REQ_SECT, 24'h012000, 16'h0}, {3'h7, 24'h1FF000, 16'h0}});
		rows.push_back('{48'h52012FFF, 4, 0, 0, 1, {REQ_BLK32, 24'h010000, 16'h0}, {3'h7, 24'h1F8000, 16'h0}});
		rows.push_back('{48'hD8012FFF, 4, 0, 0, 1, {REQ_BLK64, 24'h010000, 16'h0}, {3'h7, 24'h1F0000, 16'h0}});
		rows.push_back('{48'h60, 1, 0, 0, 1, {REQ_CHIP, 40'h0}, M_KIND});
		rows.push_back('{48'hC7, 1, 0, 0, 1, {REQ_CHIP, 40'h0}, M_KIND});
		rows.push_back('{48'h70, 1, 0, 0, 1, 0, 0});
		rows.push_back('{48'hAD0001001122, 6, 0, 0, 1, {REQ_WORD, 24'h000100, 16'h1122}, M_WORD});
		rows.push_back('{48'hAD3344, 3, 0, 0, 0, {REQ_WORD, 24'h000102, 16'h3344}, M_WORD});
		rows.push_back('{48'hAD, 1, 2, 24'hFFFF, 0, {REQ_WORD, 24'h000104, 16'h0000}, M_WORD});
		rows.push_back('{48'h04, 1, 0, 0, 0, 0, 0});
		rows.push_back('{48'h80, 1, 0, 0, 0, 0, 0});
		rows.push_back('{48'h05, 1, 1, 24'h00, 0, 0, 0});
		repeat (10) @(posedge sys_clk);
		nrst <= 1'b1;
		repeat (3) @(posedge sys_clk);
		#1;
		chk_val("status", 8'h1C, statusByte);
		chk_val("soOe", 8'h00, {7'h0, soOe});
		chk_val("reqValid", 8'h00, {7'h0, reqValid});
		foreach (rows[j]) exec(rows[j].tx, rows[j].ntx, rows[j].nrx, rows[j].rx, rows[j].wr, rows[j].e, rows[j].m, 0);
		// clock parked high between frames: the same wrapping read must still work
		host_u.idleHi = 1'b1;
		exec(48'h031FFFFF, 4, 2, 24'h1011, 0, 0, 0, 0);
		host_u.idleHi = 1'b0;
		// unknown opcode: rest of frame ignored, output stays released
		host_u.sel();
		host_u.xfer(8'h3C, 8, r, oe);
		host_u.xfer(8'h00, 8, r, oe);
		chk_val("soOe", 8'h00, {7'h0, oe});
		host_u.desel();
		// early deselect in the data byte aborts the program
		exec(48'h06, 1, 0, 0, 0, 0, 0, 0);
		host_u.sel();
		for (i = 0; i < 4; i++) host_u.xfer(i == 0 ? OP_BYTE_PROG : 8'h02, 8, r, oe);
		host_u.xfer(8'hAA, 4, r, oe);
		host_u.desel();
		chk_val("reqValid", 8'h00, {7'h0, reqValid});
		// lock set with pin low freezes protection; program into the protected range is dropped
		exec(48'h019C, 2, 0, 0, 1, 0, 0, 0);
		@(posedge sys_clk) wpN <= 1'b0;
		exec(48'h0100, 2, 0, 0, 1, 0, 0, 0);
		exec(48'h05, 1, 1, 24'h9C, 0, 0, 0, 0);
		exec(48'h0200000055, 5, 0, 0, 1, 0, 0, 0);
		@(posedge sys_clk) wpN <= 1'b1;
		exec(48'h0100, 2, 0, 0, 1, 0, 0, 0);
		exec(48'h05, 1, 1, 24'h00, 0, 0, 0, 0);
		// fill the fifo and the pending slot while the back end stalls, then drain in order
		for (i = 0; i < 18; i++) exec({8'h00, 8'h02, 16'h0004, 8'(i), 8'(i)}, 5, 0, 0, 1, 0, 0, 1);
		for (i = 0; i < 17; i++) begin
			n = 0;
			while (reqValid !== 1'b1 && n < 100) begin
				@(posedge sys_clk);
				n++;
			end
			chk_req("fifo head", {REQ_BYTE, 16'h0004, 8'(i), 8'h00, 8'(i)}, reqData & M_BYTE);
			pop();
		end
		repeat (5) @(posedge sys_clk);
		#1;
		chk_val("reqValid", 8'h00, {7'h0, reqValid});
		// top 1/32 protected, reserved bit set too: edge of the range decides
		exec(48'h0124, 2, 0, 0, 1, 0, 0, 0);
		exec(48'h021F000077, 5, 0, 0, 1, 0, 0, 0);
		exec(48'h021EFFFF77, 5, 0, 0, 1, {REQ_BYTE, 24'h1EFFFF, 16'h0077}, M_BYTE, 0);
		exec(48'h0100, 2, 0, 0, 1, 0, 0, 0);
		// array busy shows in the polled status
		exec(48'h04, 1, 0, 0, 0, 0, 0, 0);
		@(posedge sys_clk) arrayBusy <= 1'b1;
		exec(48'h05, 1, 2, 24'h0101, 0, 0, 0, 0);
		@(posedge sys_clk) arrayBusy <= 1'b0;
		// lock set, then a second reset must clear it and restore full protection
		exec(48'h0180, 2, 0, 0, 1, 0, 0, 0);
		exec(48'h05, 1, 1, 24'h80, 0, 0, 0, 0);
		@(posedge sys_clk) nrst <= 1'b0;
		repeat (10) @(posedge sys_clk);
		nrst <= 1'b1;
		repeat (3) @(posedge sys_clk);
		#1;
		chk_val("status", 8'h1C, statusByte);
		test_done();
	end
endmodule // sfe_front_end_tb
